// ---- core/phybc_control.sv ----
// Basic mode control register with its mode steering of the MAC and line paths.
//
// Summary of operation
// - 16-bit register, independent of MAC configuration
// - Reset bit restores defaults, idles machines
// - Reset reads one, blocks access, self-clears
// - Loopback disables line side, loops MAC
// - Loopback receive valid within 512 bits
// - Collision test keeps collision in loopback
// - Strap mode takes rate from pin
// - Rate from negotiation or rate bit
// - Strap mode takes negotiation enable from pin
// - Negotiation off lets rate, duplex bits rule
// - Low power silences outputs, tristates transmitter
// - Low power entry defaults latching bits
// - Isolate floats MAC outputs, ignores inputs
// - Isolate resets one for address zero
// - Restart write ignored without negotiation
// - Restart bit self-clears once started
// - Strap mode takes duplex from pin
// - Duplex from negotiation or duplex bit
// - Loopback ignores the duplex bit
// - Reserved bits read zero, read-only
// - Latching high flag held until read
// - Latching low flag held until read
`timescale 1ns/10ps
`default_nettype none
module phybc_control (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   input  wire logic        strap_or_register_select_pin,
   input  wire logic        rate_select_pin,
   input  wire logic        negotiation_select_pin,
   input  wire logic        duplex_select_pin,
   input  wire logic [4:0]  phy_addr_pins,
   input  wire logic [4:0]  mgmt_reg_addr,
   input  wire logic        mgmt_wr_en,
   input  wire logic        mgmt_rd_en,
   input  wire logic [15:0] mgmt_wdata,
   output var  logic [15:0] mgmt_rdata,
   output var  logic        mgmt_ack,
   input  wire logic        neg_rate_100,
   input  wire logic        neg_full_duplex,
   input  wire logic        neg_started,
   input  wire logic        neg_complete_evt,
   input  wire logic        remote_fault_evt,
   input  wire logic        jabber_evt,
   input  wire logic        link_ok,
   input  wire logic [3:0]  mac_txd,
   input  wire logic        mac_tx_en,
   input  wire logic        mac_tx_er,
   output var  logic [3:0]  mac_rxd,
   output var  logic        mac_rx_dv,
   output var  logic        mac_rx_er,
   output var  logic        mac_crs,
   output var  logic        mac_col,
   output var  logic        mac_out_oe,
   input  wire logic [3:0]  line_rxd,
   input  wire logic        line_rx_dv,
   input  wire logic        line_rx_er,
   input  wire logic        line_crs,
   input  wire logic        line_col,
   output var  logic [3:0]  line_txd,
   output var  logic        line_tx_en,
   output var  logic        line_tx_er,
   output var  logic        line_transmit_tristate,
   output var  logic        line_rx_enable,
   output var  logic        col_detect_enable,
   output var  logic        speed_100,
   output var  logic        full_duplex,
   output var  logic        neg_enable,
   output var  logic        neg_restart,
   output var  logic        soft_reset_active,
   output var  logic        power_down
);
   // ----------------------------------------------------------------
   // Strap pin synchronisers
   // ----------------------------------------------------------------
   logic [8:0] pins_s;

   phybc_sync2 #(.W(9)) u_sync (
      .ref_clk  (ref_clk),
      .srst     (1'b0),
      .async_in ({strap_or_register_select_pin, rate_select_pin, negotiation_select_pin,
                  duplex_select_pin, phy_addr_pins}),
      .sync_out (pins_s)
   );

   logic       sw_mode;
   logic       rate_pin_s;
   logic       neg_pin_s;
   logic       dpx_pin_s;
   logic [4:0] addr_pins_s;
   assign sw_mode     = pins_s[8];
   assign rate_pin_s  = pins_s[7];
   assign neg_pin_s   = pins_s[6];
   assign dpx_pin_s   = pins_s[5];
   assign addr_pins_s = pins_s[4:0];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic        restart_reg;
   logic        restart_next;
   logic [4:0]  addr_strap_reg;
   logic [4:0]  busy_cnt_reg;
   logic        busy;
   logic        lp_prev_reg;
   logic        strap_load_reg;

   assign busy = (busy_cnt_reg != phybc_pkg::CNT_ZERO);

   // ----------------------------------------------------------------
   // Decode of management accesses
   // ----------------------------------------------------------------
   logic        hit_ctrl;
   logic        hit_stat;
   logic        wr_ctrl;
   logic        wr_soft_reset;
   logic        wr_neg_en;
   logic        stat_read;
   logic [15:0] iso_default;
   logic [15:0] ctrl_default;

   assign hit_ctrl      = (mgmt_reg_addr == phybc_pkg::ADDR_CONTROL);
   assign hit_stat      = (mgmt_reg_addr == phybc_pkg::ADDR_LATCH_STAT);
   assign wr_ctrl       = mgmt_wr_en & hit_ctrl & ~busy;
   assign wr_soft_reset = wr_ctrl & mgmt_wdata[phybc_pkg::BIT_RESET];
   assign wr_neg_en     = sw_mode ? mgmt_wdata[phybc_pkg::BIT_NEG_EN] : neg_pin_s;
   assign stat_read     = mgmt_rd_en & hit_stat & ~busy;
   assign iso_default   = (addr_strap_reg == phybc_pkg::PHY_ADDR_ZERO) ? phybc_pkg::CTRL_ISO_MASK
                                                                     : phybc_pkg::REG_ZERO;
   assign ctrl_default  = phybc_pkg::CTRL_DEFAULT | iso_default;

   // ----------------------------------------------------------------
   // Effective operating mode
   // ----------------------------------------------------------------
   logic lb_bit;
   logic lp_bit;
   logic iso_bit;
   logic coltest_bit;
   logic eff_neg_en;
   logic eff_rate;
   logic eff_duplex;
   logic lp_enter;

   assign lb_bit      = ctrl_reg[phybc_pkg::BIT_LOOPBACK];
   assign lp_bit      = ctrl_reg[phybc_pkg::BIT_LOW_POWER];
   assign iso_bit     = ctrl_reg[phybc_pkg::BIT_ISOLATE];
   assign coltest_bit = ctrl_reg[phybc_pkg::BIT_COL_TEST];
   assign eff_neg_en  = sw_mode ? ctrl_reg[phybc_pkg::BIT_NEG_EN] : neg_pin_s;
   assign eff_rate    = ~sw_mode ? rate_pin_s :
                        (eff_neg_en ? neg_rate_100 : ctrl_reg[phybc_pkg::BIT_RATE]);
   assign eff_duplex  = lb_bit ? 1'b1 : ~sw_mode ? dpx_pin_s :
                        (eff_neg_en ? neg_full_duplex : ctrl_reg[phybc_pkg::BIT_DUPLEX]);
   assign lp_enter    = lp_bit & ~lp_prev_reg;

   // ----------------------------------------------------------------
   // Next value of the control bits
   // ----------------------------------------------------------------
   // defaults on soft reset
   // Held at defaults for the whole reset so a stray write cannot leak in.
   // The first enabled cycle after a hard reset reloads them with the settled straps.
   assign ctrl_next = (busy | strap_load_reg) ? ctrl_default :
                      wr_ctrl ? (mgmt_wdata & phybc_pkg::CTRL_WR_MASK) : ctrl_reg;

   // restart self-clears
   // A restart written in the same cycle as the start indication is kept.
   assign restart_next = busy ? 1'b0 :
                         (wr_ctrl & ~wr_soft_reset & mgmt_wdata[phybc_pkg::BIT_RESTART] & wr_neg_en) ? 1'b1 :
                         neg_started ? 1'b0 : restart_reg;

   // ----------------------------------------------------------------
   // Control register and soft reset counter
   // ----------------------------------------------------------------
   // Straps are sampled again through a soft reset so the isolate default follows them.
   always_ff @(posedge ref_clk)
   begin
      if (srst || (clk_en && busy))
         addr_strap_reg <= addr_pins_s;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         ctrl_reg     <= phybc_pkg::CTRL_DEFAULT;
         restart_reg  <= 1'b0;
         busy_cnt_reg <= phybc_pkg::CNT_ZERO;
         lp_prev_reg  <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl_reg    <= ctrl_next;
         restart_reg <= restart_next;
         lp_prev_reg <= lp_bit;
         if (wr_soft_reset)
            busy_cnt_reg <= phybc_pkg::SOFT_RST_CYC;
         else if (busy)
            busy_cnt_reg <= busy_cnt_reg - phybc_pkg::CNT_ONE;
      end
   end

   // The isolate default follows the address straps once they settle through
   // the synchroniser, so the first cycles after power-up are corrected here.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         strap_load_reg <= 1'b1;
      else if (clk_en)
         strap_load_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Latching status flags
   // ----------------------------------------------------------------
   logic [3:0] lat_flags;
   logic       lat_default;
   assign lat_default = lp_enter | busy;

   phybc_latch_bit #(.LATCH_HIGH(1'b1)) u_neg_done (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .to_default(lat_default),
      .read_strobe(stat_read), .monitor(neg_complete_evt), .flag_reg(lat_flags[0]));
   phybc_latch_bit #(.LATCH_HIGH(1'b1)) u_rem_fault (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .to_default(lat_default),
      .read_strobe(stat_read), .monitor(remote_fault_evt), .flag_reg(lat_flags[1]));
   phybc_latch_bit #(.LATCH_HIGH(1'b0)) u_link_up (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .to_default(lat_default),
      .read_strobe(stat_read), .monitor(link_ok), .flag_reg(lat_flags[2]));
   phybc_latch_bit #(.LATCH_HIGH(1'b1)) u_jabber (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .to_default(lat_default),
      .read_strobe(stat_read), .monitor(jabber_evt), .flag_reg(lat_flags[3]));

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [15:0] ctrl_view;
   logic [15:0] stat_view;
   logic [15:0] rd_mux;

   assign ctrl_view = {busy, ctrl_reg[14:10], restart_reg, ctrl_reg[8:7], 7'h00};
   assign stat_view = {10'h000, lat_flags[0], lat_flags[1], 1'b0, lat_flags[2], lat_flags[3], 1'b0};
   assign rd_mux    = hit_ctrl ? ctrl_view :
                      (hit_stat & ~busy) ? stat_view : phybc_pkg::REG_ZERO;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mgmt_rdata <= phybc_pkg::REG_ZERO;
         mgmt_ack   <= 1'b0;
      end
      else if (clk_en)
      begin
         mgmt_ack   <= mgmt_rd_en | mgmt_wr_en;
         mgmt_rdata <= mgmt_rd_en ? rd_mux : phybc_pkg::REG_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // Data path steering
   // ----------------------------------------------------------------
   logic       tx_live;
   logic [3:0] txd_in;
   logic       tx_en_in;
   logic       tx_er_in;
   logic       col_en;
   logic [3:0] rxd_sel;
   logic       rx_dv_sel;
   logic       rx_er_sel;
   logic       crs_sel;
   logic       col_sel;

   assign tx_live   = ~iso_bit & ~lp_bit & ~busy;
   assign txd_in    = tx_live ? mac_txd : phybc_pkg::NIBBLE_ZERO;
   assign tx_en_in  = tx_live & mac_tx_en;
   assign tx_er_in  = tx_live & mac_tx_er;
   assign col_en    = ~lb_bit | coltest_bit;
   assign rxd_sel   = lb_bit ? txd_in   : line_rxd;
   assign rx_dv_sel = lb_bit ? tx_en_in : line_rx_dv;
   assign rx_er_sel = lb_bit ? tx_er_in : line_rx_er;
   assign crs_sel   = lb_bit ? tx_en_in : line_crs;
   assign col_sel   = col_en & (coltest_bit ? tx_en_in : line_col);

   // The loop adds one register stage, far inside the allowed delay, which
   // keeps every MAC output on a flip-flop.
   // loopback delay
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mac_rxd                <= phybc_pkg::NIBBLE_ZERO;
         mac_rx_dv              <= 1'b0;
         mac_rx_er              <= 1'b0;
         mac_crs                <= 1'b0;
         mac_col                <= 1'b0;
         mac_out_oe             <= 1'b0;
         line_txd               <= phybc_pkg::NIBBLE_ZERO;
         line_tx_en             <= 1'b0;
         line_tx_er             <= 1'b0;
         line_transmit_tristate <= 1'b1;
         line_rx_enable         <= 1'b0;
         col_detect_enable      <= 1'b0;
      end
      else if (clk_en)
      begin
         mac_rxd                <= (lp_bit | busy) ? phybc_pkg::NIBBLE_ZERO : rxd_sel;
         mac_rx_dv              <= ~lp_bit & ~busy & rx_dv_sel;
         mac_rx_er              <= ~lp_bit & ~busy & rx_er_sel;
         mac_crs                <= ~lp_bit & ~busy & crs_sel;
         mac_col                <= ~lp_bit & ~busy & col_sel;
         mac_out_oe             <= ~iso_bit;
         line_txd               <= lb_bit ? phybc_pkg::NIBBLE_ZERO : txd_in;
         line_tx_en             <= ~lb_bit & tx_en_in;
         line_tx_er             <= ~lb_bit & tx_er_in;
         line_transmit_tristate <= lb_bit | lp_bit;
         line_rx_enable         <= ~lb_bit & ~lp_bit;
         col_detect_enable      <= col_en & ~lp_bit;
      end
   end

   // ----------------------------------------------------------------
   // Mode outputs
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         speed_100         <= 1'b0;
         full_duplex       <= 1'b0;
         neg_enable        <= 1'b0;
         neg_restart       <= 1'b0;
         soft_reset_active <= 1'b0;
         power_down        <= 1'b0;
      end
      else if (clk_en)
      begin
         speed_100         <= eff_rate;
         full_duplex       <= eff_duplex;
         neg_enable        <= eff_neg_en;
         neg_restart       <= restart_next & ~restart_reg;
         soft_reset_active <= busy | wr_soft_reset;
         power_down        <= lp_bit;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_iso_float;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && iso_bit) |=> !mac_out_oe;
   endproperty
   a_iso_float: assert property (p_iso_float) else $error("isolate did not float MAC outputs");

   property p_lb_dv;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && lb_bit && mac_tx_en && tx_live) |=> (mac_rx_dv && !line_tx_en);
   endproperty
   a_lb_dv: assert property (p_lb_dv) else $error("loopback receive valid late");

   property p_lp_quiet;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && lp_bit) |=> (line_transmit_tristate && !mac_rx_dv && !mac_col && power_down);
   endproperty
   a_lp_quiet: assert property (p_lp_quiet) else $error("low power left outputs active");

   property p_busy_read;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && busy && mgmt_rd_en && hit_ctrl) |=> (mgmt_ack && mgmt_rdata[phybc_pkg::BIT_RESET]);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("reset bit not read as one");

   property p_restart_ignored;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && !restart_reg && !neg_started && wr_ctrl && !wr_neg_en) |=> !restart_reg;
   endproperty
   a_restart_ignored: assert property (p_restart_ignored) else $error("restart taken while disabled");

   property p_soft_defaults;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && busy) |=> (ctrl_reg == $past(ctrl_default) && !restart_reg);
   endproperty
   a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset kept old values");

   property p_coltest_lb;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && lb_bit && coltest_bit && tx_en_in) |=> mac_col;
   endproperty
   a_coltest_lb: assert property (p_coltest_lb) else $error("collision test lost in loopback");

   property p_hw_rate;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && !sw_mode) |=> (speed_100 == $past(rate_pin_s));
   endproperty
   a_hw_rate: assert property (p_hw_rate) else $error("strap rate not followed");

   property p_sw_duplex;
      @(posedge ref_clk) disable iff (srst)
      (clk_en && sw_mode && !eff_neg_en && !lb_bit) |=> (full_duplex == $past(ctrl_reg[phybc_pkg::BIT_DUPLEX]));
   endproperty
   a_sw_duplex: assert property (p_sw_duplex) else $error("duplex bit not followed");
endmodule // phybc_control
`default_nettype wire

// ---- core/phybc_pkg.sv ----
// Package of register layout, defaults and timing constants for the basic control register block.
package phybc_pkg;
   // ----------------------------------------------------------------
   // Register map and field positions
   // ----------------------------------------------------------------
   localparam logic [4:0]  ADDR_CONTROL    = 5'h00;
   localparam logic [4:0]  ADDR_LATCH_STAT = 5'h01;
   localparam int          BIT_RESET       = 15;
   localparam int          BIT_LOOPBACK    = 14;
   localparam int          BIT_RATE        = 13;
   localparam int          BIT_NEG_EN      = 12;
   localparam int          BIT_LOW_POWER   = 11;
   localparam int          BIT_ISOLATE     = 10;
   localparam int          BIT_RESTART     = 9;
   localparam int          BIT_DUPLEX      = 8;
   localparam int          BIT_COL_TEST    = 7;
   localparam int          BIT_NEG_DONE    = 5;
   localparam int          BIT_REM_FAULT   = 4;
   localparam int          BIT_LINK_UP     = 2;
   localparam int          BIT_JABBER      = 1;
   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_DEFAULT    = 16'h3000;
   localparam logic [15:0] CTRL_ISO_MASK   = 16'h0400;
   localparam logic [15:0] CTRL_WR_MASK    = 16'h7D80;
   localparam logic [15:0] REG_ZERO        = 16'h0000;
   localparam logic [4:0]  PHY_ADDR_ZERO   = 5'h00;
   localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          LB_MAX_BITS     = 512;
   localparam int          BIT_TIME_NS     = 10;
   localparam int          LB_MAX_CYC      = (LB_MAX_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
   localparam logic [4:0]  SOFT_RST_CYC    = 5'h10;
   localparam logic [4:0]  CNT_ONE         = 5'h01;
   localparam logic [4:0]  CNT_ZERO        = 5'h00;
endpackage

// ---- core/phybc_sync2.sv ----
// Two flip-flop synchroniser for asynchronous strap pins.
`timescale 1ns/10ps
`default_nettype none
module phybc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   // The first stage feeds only the second stage; the clock enable does not gate
   // it so a frozen block still sees settled pin levels on release.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // phybc_sync2
`default_nettype wire

// ---- core/phybc_latch_bit.sv ----
// One latching status flag that records a high or a low event until read.
`timescale 1ns/10ps
`default_nettype none
module phybc_latch_bit #(
   parameter bit LATCH_HIGH = 1'b1
) (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   input  wire logic to_default,
   input  wire logic read_strobe,
   input  wire logic monitor,
   output var  logic flag_reg
);
   logic event_seen;
   assign event_seen = LATCH_HIGH ? monitor : ~monitor;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         flag_reg <= 1'b0;
      else if (clk_en)
      begin
         // An event in the same cycle as a return to default still sets the flag.
         if (to_default)
            flag_reg <= event_seen & LATCH_HIGH;
         else if (read_strobe)
            flag_reg <= monitor;
         else if (event_seen)
            flag_reg <= LATCH_HIGH;
      end
   end
endmodule // phybc_latch_bit
`default_nettype wire

// ---- verif/phybc_mac_model.sv ----
// MAC transmit model that sends a counting nibble stream while enabled.
`timescale 1ns/10ps
`default_nettype none
module phybc_mac_model (
   input  wire logic       ref_clk,
   input  wire logic       go,
   output var  logic [3:0] mac_txd,
   output var  logic       mac_tx_en,
   output var  logic       mac_tx_er
);
   // The nibble changes every cycle, so stale data never looks like live data.
   initial
   begin
      mac_txd   = 4'h0;
      mac_tx_en = 1'b0;
      mac_tx_er = 1'b0;
   end
   always @(posedge ref_clk)
   begin
      mac_txd   <= mac_txd + 4'h1;
      mac_tx_en <= go;
   end
endmodule // phybc_mac_model
`default_nettype wire

// ---- verif/phy_basic_control_register_bench.sv ----
// Self-checking bench for the basic control register block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module phy_basic_control_register_bench;
   logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, strap_or_register_select_pin = 1'b1;
   logic rate_select_pin = 1'b0, negotiation_select_pin = 1'b1, duplex_select_pin = 1'b0;
   logic mgmt_wr_en = 1'b0, mgmt_rd_en = 1'b0, neg_rate_100 = 1'b0, neg_full_duplex = 1'b0;
   logic neg_started = 1'b0, neg_complete_evt = 1'b0, remote_fault_evt = 1'b0, jabber_evt = 1'b0;
   logic link_ok = 1'b0, tx_go = 1'b0;
   logic [4:0]  phy_addr_pins = 5'h01, mgmt_reg_addr = 5'h00;
   logic [15:0] mgmt_wdata = 16'h0000;
   wire logic [15:0] mgmt_rdata;
   wire logic [3:0]  mac_txd, mac_rxd, line_txd;
   wire logic mgmt_ack, mac_tx_en, mac_tx_er, mac_rx_dv, mac_rx_er, mac_crs, mac_col, mac_out_oe;
   wire logic line_tx_en, line_tx_er, line_transmit_tristate, line_rx_enable, col_detect_enable;
   wire logic speed_100, full_duplex, neg_enable, neg_restart, soft_reset_active, power_down;
   wire logic [3:0] line_rxd = 4'h0;
   wire logic line_rx_dv = 1'b0, line_rx_er = 1'b0, line_crs = 1'b0, line_col = 1'b0;
   logic [31:0] exp_q[$];
   int n_fail = 0, compares = 0, cyc = 0;

   phybc_control u_dut (.*);
   phybc_mac_model u_mac (.ref_clk(ref_clk), .go(tx_go), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
                          .mac_tx_er(mac_tx_er));

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One access; the expected read value under a mask is queued for the monitor.
   // A write always answers with zero read data.
   task automatic acc(input logic wr, input logic [15:0] d, input logic [15:0] m, input logic [15:0] e);
      @(posedge ref_clk);
      mgmt_wr_en <= wr;
      mgmt_rd_en <= ~wr;
      mgmt_wdata <= d;
      exp_q.push_back(wr ? {16'hFFFF, 16'h0000} : {m, e});
      @(posedge ref_clk);
      mgmt_wr_en <= 1'b0;
      mgmt_rd_en <= 1'b0;
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   // ----------------------------------------------------------------
   // Monitor and watchdog
   // ----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_fail++;
         summarize();
      end
      if (mgmt_ack === 1'b1)
      begin
         `CHK(mgmt_rdata & exp_q[0][31:16], exp_q[0][15:0])
         void'(exp_q.pop_front());
      end
   end

   initial
   begin
      logic [1:0] r;
      int i;
      void'($urandom(26167));
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      acc(1'b0, 16'h0000, 16'hFFFF, 16'h3000);
      mgmt_reg_addr <= 5'h1F;
      acc(1'b0, 16'h0000, 16'hFFFF, 16'h0000);
      mgmt_reg_addr <= 5'h00;
      note("defaults");
      acc(1'b1, 16'h0380, 16'h0000, 16'h0000);
      acc(1'b0, 16'h0000, 16'hFFFF, 16'h0180);
      `CHK({full_duplex, speed_100, neg_enable}, 3'h4)
      note("manual mode");
      acc(1'b1, 16'h1200, 16'h0000, 16'h0000);
      #1;
      `CHK(neg_restart, 1'b1)
      acc(1'b0, 16'h0000, 16'h0200, 16'h0200);
      neg_started <= 1'b1;
      @(posedge ref_clk);
      neg_started <= 1'b0;
      repeat (2) @(posedge ref_clk);
      acc(1'b0, 16'h0000, 16'hFFFF, 16'h1000);
      neg_rate_100 <= 1'b1;
      neg_full_duplex <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK({speed_100, full_duplex, neg_enable}, 3'h7)
      note("restart");
      acc(1'b1, 16'h4080, 16'h0000, 16'h0000);
      tx_go <= 1'b1;
      for (i = 0; i < phybc_pkg::LB_MAX_CYC && mac_rx_dv !== 1'b1; i++) @(posedge ref_clk);
      `CHK(mac_rx_dv, 1'b1)
      @(posedge ref_clk);
      `CHK({line_transmit_tristate, line_rx_enable, col_detect_enable, full_duplex, mac_col, mac_crs, line_tx_en}, 7'h5E)
      `CHK(mac_rxd, mac_txd - 4'h1)
      tx_go <= 1'b0;
      acc(1'b1, 16'h0000, 16'h0000, 16'h0000);
      note("loopback");
      r = 2'($urandom);
      rate_select_pin <= r[0];
      duplex_select_pin <= r[1];
      negotiation_select_pin <= 1'b0;
      strap_or_register_select_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK({speed_100, full_duplex, neg_enable}, {r[0], r[1], 1'b0})
      strap_or_register_select_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      note("strap mode");
      mgmt_reg_addr <= 5'h01;
      link_ok <= 1'b1;
      jabber_evt <= 1'b1;
      @(posedge ref_clk);
      jabber_evt <= 1'b0;
      acc(1'b0, 16'h0000, 16'h0036, 16'h0002);
      acc(1'b0, 16'h0000, 16'h0036, 16'h0004);
      mgmt_reg_addr <= 5'h00;
      note("latching");
      acc(1'b1, 16'h0800, 16'h0000, 16'h0000);
      repeat (2) @(posedge ref_clk);
      `CHK({power_down, line_transmit_tristate, mac_rx_dv}, 3'h6)
      mgmt_reg_addr <= 5'h01;
      acc(1'b0, 16'h0000, 16'h0036, 16'h0000);
      note("low power");
      phy_addr_pins <= 5'h00;
      mgmt_reg_addr <= 5'h00;
      repeat (4) @(posedge ref_clk);
      acc(1'b1, 16'h8000, 16'h0000, 16'h0000);
      acc(1'b0, 16'h0000, 16'h8000, 16'h8000);
      acc(1'b1, 16'h0100, 16'h0000, 16'h0000);
      for (i = 0; i < 40 && soft_reset_active !== 1'b0; i++) @(posedge ref_clk);
      acc(1'b0, 16'h0000, 16'hFFFF, 16'h3400);
      `CHK(mac_out_oe, 1'b0)
      note("soft reset");
      repeat (4) @(posedge ref_clk);
      `CHK(exp_q.size(), 0)
      summarize();
   end
endmodule // phy_basic_control_register_bench
`default_nettype wire
